// *** gls_consts.vh ***
`ifndef GLS_CONSTS_VH
`define GLS_CONSTS_VH

// ----------------------------------------------------------------------------
// Host register offsets
// ----------------------------------------------------------------------------
`define GLS_ADDR_LOCK_TIME 8'h14
`define GLS_ADDR_STATUS 8'h15
`define GLS_ADDR_LOCK_MODE 8'h16
`define GLS_ADDR_CRASH_WIN 8'h24
`define GLS_ADDR_VCAP 8'h26
`define GLS_ADDR_VRES 8'h27
`define GLS_ADDR_VDIV_LO 8'h2A
`define GLS_ADDR_VDIV_HI 8'h2B
`define GLS_ADDR_AUD_CTRL 8'h31
`define GLS_ADDR_ACAP 8'h39
`define GLS_ADDR_ARES 8'h3A
`define GLS_ADDR_ANUM_LO 8'h3B
`define GLS_ADDR_ANUM_HI 8'h3C
`define GLS_ADDR_ADEN_LO 8'h3D
`define GLS_ADDR_ADEN_HI 8'h3E
`define GLS_ADDR_LINE_RST 8'h83

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GLS_LM_GENLOCK_BIT 0
`define GLS_LM_DRIFT_BIT 1
`define GLS_CW_RUN_MSB 2
`define GLS_CW_RUN_LSB 0
`define GLS_CW_CRASH_MSB 7
`define GLS_CW_CRASH_LSB 4
`define GLS_AC_RATE_OVR_BIT 2
`define GLS_AC_HIGH_MULT_BIT 5
`define GLS_AC_RATE_MSB 10
`define GLS_AC_RATE_LSB 8
`define GLS_LR_TOGGLE_BIT 15
`define GLS_LR_VOFS_MSB 10
`define GLS_LR_VOFS_LSB 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GLS_RST_LOCK_MODE 16'h0001
`define GLS_RST_CRASH_WIN 16'h0047
`define GLS_RST_VCAP 16'h0010
`define GLS_RST_VRES 16'h0025
`define GLS_RST_VDIV 32'h00000001
`define GLS_RST_AUD_CTRL 16'h0000
`define GLS_RST_ACAP 16'h0010
`define GLS_RST_ARES 16'h0025
`define GLS_RST_ANUM 32'h00000001
`define GLS_RST_ADEN 32'h00000001
`define GLS_RST_LINE_RST 16'h0000

// ----------------------------------------------------------------------------
// Audio ratio constants and rate codes
// ----------------------------------------------------------------------------
`define GLS_RATE_96K 3'h4
`define GLS_RATIO_DEFAULT 12'hC00
`define GLS_RATIO_96K_LOW 12'h400
`define GLS_RATIO_96K_HIGH 12'h600

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GLS_CLK_MHZ 200
`define GLS_REF_TIMEOUT_NS 100000
`define GLS_DRIFT_LOCK_LINES 16'h0100
`define GLS_CRASH_LINE_UNIT 16'h0004
`define GLS_PERIOD_TOL 24'h000008

`endif

// *** gls_sync.v ***
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs; only the second stage is visible.
module gls_sync #(
  parameter W = 1
) (
  input wire clk, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire [W-1:0] din, // Asynchronous input.
  output reg [W-1:0] dout // Synchronised output.
);

  reg [W-1:0] meta;

  // The first stage feeds the second stage and nothing else.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // gls_sync

// *** gls_span_counter.v ***
`timescale 1ns/1ps
// Saturating cycle counter with synchronous clear.
module gls_span_counter #(
  parameter W = 16
) (
  input wire clk, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire clear, // Restart at zero.
  input wire count_en, // Count this cycle.
  output reg [W-1:0] count // Current count.
);

  // Saturation keeps a long gap from wrapping back into a short one.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= {W{1'b0}};
    else if (clear)
      count <= {W{1'b0}};
    else if (count_en && (count != {W{1'b1}}))
      count <= count + {{(W-1){1'b0}}, 1'b1};
  end

endmodule // gls_span_counter

// *** gls_lock_ctrl.v ***
`timescale 1ns/1ps
`include "gls_consts.vh"

// Contract
// (R01) Audio loop stays locked to the video clock by default, no programming.
// (R02) Host writes audio numerator and denominator for custom video or audio clocks.
// (R03) Ratio 3072, except rate select 100b: 1024 if high-multiple low, else 1536.
// (R04) Host reduces audio numerator and denominator to lowest terms first.
// (R05) Host uses ratio 1024 for custom audio clock divider computation.
// (R06) High-multiple audio enable is bit 5 of audio control, low after reset.
// (R07) After reset the video loop crash locks, allowing phase jumps.
// (R08) Crash behaviour is set by the crash duration field at 24h.
// (R09) Bit 1 of 16h high forces drift locking.
// (R10) In genlock mode a returning reference is reacquired by drift locking.
// (R11) Locking interval runs from reference applied until lock-loss drops.
// (R12) Video loop capacitive at 26h, resistive at 27h.
// (R13) Host picks video resistive by ceiling formula, capacitive at most resistive minus 21.
// (R14) Host keeps video resistive in 32..42 and capacitive above 10.
// (R15) Audio loop capacitive at 39h, resistive at 3Ah.
// (R16) Host derives audio filter values by the same formula.
// (R17) Host keeps audio resistive in 32..42 and capacitive above 10.
// (R18) Horizontal phase jump without reference loss: drift slowly, flags stay low.
// (R19) Run-window bits 24h[2:0] all zero: crash lock on every horizontal disturbance.
// (R20) Phase jump with reference divider above 1 may lose vertical alignment.
// (R21) Toggling 83h bit 15 resets line counters, then outputs follow vertical offset.
// (R22) Line counter reset fires once per written one-then-zero of that bit.
module gls_lock_ctrl #(
  parameter REF_TIMEOUT_CYCLES = `GLS_REF_TIMEOUT_NS * `GLS_CLK_MHZ / 1000,
  parameter [31:0] AUD_DEFAULT_NUM = `GLS_RST_ANUM,
  parameter [31:0] AUD_DEFAULT_DEN = `GLS_RST_ADEN
) (
  input wire clk, // System clock, 200 MHz.
  input wire rst_b, // Asynchronous reset, active low.
  input wire host_wr, // Host register write strobe.
  input wire host_rd, // Host register read strobe.
  input wire [7:0] host_addr, // Host register address.
  input wire [15:0] host_wdata, // Host write data.
  output reg [15:0] host_rdata, // Host read data, valid the cycle after host_rd.
  input wire ref_hsync, // Reference horizontal sync pin.
  input wire ref_vsync, // Reference vertical sync pin.
  input wire [2:0] audio_rate_select, // Audio sample rate select pins.
  output reg lock_lost, // High while not locked.
  output reg ref_lost, // High while no reference is seen.
  output reg lock_crash_mode, // High while crash acquisition runs.
  output reg phase_jump, // One-cycle pulse when a crash lock starts.
  output reg drift_active, // High while outputs drift to a new phase.
  output reg [11:0] audio_ratio_const, // Audio ratio constant in use.
  output reg [31:0] audio_fb_div, // Audio loop numerator in use.
  output reg [31:0] audio_ref_div, // Audio loop denominator in use.
  output reg audio_custom_div, // Host has written the audio dividers.
  output reg [31:0] video_ref_div, // Video reference divider.
  output reg [15:0] video_cap, // Video loop capacitive setting.
  output reg [15:0] video_res, // Video loop resistive setting.
  output reg [15:0] audio_cap, // Audio loop capacitive setting.
  output reg [15:0] audio_res, // Audio loop resistive setting.
  output reg line_counter_reset, // One-cycle pulse on line counter reset.
  output reg line_frame_start, // One-cycle pulse at the offset line.
  output reg [15:0] line_count, // Lines since the last alignment point.
  output reg vphase_aligned // Line counters aligned to input vertical sync.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam [1:0] ST_FREE = 2'b00;
  localparam [1:0] ST_CRASH = 2'b01;
  localparam [1:0] ST_DRIFT = 2'b10;
  localparam [1:0] ST_LOCKED = 2'b11;
  localparam [23:0] REF_TIMEOUT = REF_TIMEOUT_CYCLES[23:0];

  reg [15:0] lock_mode;
  reg [15:0] crash_win;
  reg [15:0] aud_ctrl;
  reg [15:0] line_rst;
  reg [1:0] state;
  reg [1:0] next_state;
  reg hs_d;
  reg vs_d;
  reg seen_ref;
  reg was_locked;
  reg [23:0] last_period;
  reg [15:0] acq_lines;
  reg [15:0] drift_lines;
  reg [15:0] lock_time;
  reg [15:0] line_total;
  reg lr_prev;
  reg align_pending;
  wire hs_s;
  wire vs_s;
  wire [2:0] rate_pin;
  wire hs_rise;
  wire vs_rise;
  wire [23:0] period_cnt;
  wire [15:0] lock_span;
  wire [23:0] period_diff;
  wire disturbance;
  wire genlock_en;
  wire [2:0] eff_rate;
  wire [31:0] crash_target_w;
  wire [15:0] crash_target;
  wire [15:0] acq_target;
  wire lr_fall;
  wire acquiring;

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  gls_sync #(.W(5)) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din({ref_hsync, ref_vsync, audio_rate_select}),
    .dout({hs_s, vs_s, rate_pin})
  );

  // Edges are taken from the synchronised copies only.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hs_d <= 1'b0;
      vs_d <= 1'b0;
    end
    else
    begin
      hs_d <= hs_s;
      vs_d <= vs_s;
    end
  end

  assign hs_rise = hs_s & ~hs_d;
  assign vs_rise = vs_s & ~vs_d;

  // --------------------------------------------------------------------------
  // Reference period measurement
  // --------------------------------------------------------------------------
  gls_span_counter #(.W(24)) u_period (
    .clk(clk),
    .rst_b(rst_b),
    .clear(hs_rise),
    .count_en(1'b1),
    .count(period_cnt)
  );

  assign acquiring = (state == ST_CRASH) || (state == ST_DRIFT);

  // Counts the cycles spent acquiring, from reference applied to lock.
  gls_span_counter #(.W(16)) u_lock_span (
    .clk(clk),
    .rst_b(rst_b),
    .clear(state == ST_FREE),
    .count_en(acquiring),
    .count(lock_span)
  );

  assign period_diff = (period_cnt > last_period) ? (period_cnt - last_period) : (last_period - period_cnt);
  // A period far off the last one is a disturbance of the horizontal input.
  assign disturbance = hs_rise && seen_ref && (period_diff > `GLS_PERIOD_TOL);
  assign genlock_en = lock_mode[`GLS_LM_GENLOCK_BIT];
  assign crash_target_w = ({28'h0000000, crash_win[`GLS_CW_CRASH_MSB:`GLS_CW_CRASH_LSB]} + 32'h00000001)
    * {16'h0000, `GLS_CRASH_LINE_UNIT}; // R08
  assign crash_target = crash_target_w[15:0];
  assign acq_target = (state == ST_DRIFT) ? `GLS_DRIFT_LOCK_LINES : crash_target;

  // Reference presence: lost once no edge arrives within the timeout.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_ref <= 1'b0;
      last_period <= 24'h000000;
      ref_lost <= 1'b1;
    end
    else
    begin
      if (hs_rise)
      begin
        seen_ref <= 1'b1;
        last_period <= period_cnt;
      end
      else if (period_cnt >= REF_TIMEOUT)
        seen_ref <= 1'b0;
      ref_lost <= ~seen_ref;
    end
  end

  // --------------------------------------------------------------------------
  // Lock state machine
  // --------------------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_FREE:
      begin
        if (genlock_en && seen_ref && hs_rise)
        begin
          if (lock_mode[`GLS_LM_DRIFT_BIT] || was_locked) // R09 R10
            next_state = ST_DRIFT;
          else
            next_state = ST_CRASH; // R07
        end
      end
      ST_CRASH, ST_DRIFT:
      begin
        if (!genlock_en || !seen_ref)
          next_state = ST_FREE;
        else if (acq_lines >= acq_target)
          next_state = ST_LOCKED;
      end
      ST_LOCKED:
      begin
        if (!genlock_en || !seen_ref)
          next_state = ST_FREE;
        else if (disturbance && (crash_win[`GLS_CW_RUN_MSB:`GLS_CW_RUN_LSB] == 3'h0)) // R19
          next_state = ST_CRASH;
      end
      default:
        next_state = ST_FREE;
    endcase
  end

  // State, lock-loss and drift tracking. Lock-loss drops on the edge the
  // loop reaches lock, which closes the measured locking interval.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_FREE;
      was_locked <= 1'b0;
      acq_lines <= 16'h0000;
      drift_lines <= 16'h0000;
      drift_active <= 1'b0;
      lock_lost <= 1'b1;
      lock_crash_mode <= 1'b0;
      phase_jump <= 1'b0;
      lock_time <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      lock_lost <= (next_state != ST_LOCKED); // R11
      lock_crash_mode <= (next_state == ST_CRASH);
      phase_jump <= (next_state == ST_CRASH) && (state != ST_CRASH); // R07
      if (next_state != state)
        acq_lines <= 16'h0000;
      else if (acquiring && hs_rise && (acq_lines != 16'hFFFF))
        acq_lines <= acq_lines + 16'h0001;
      if ((next_state == ST_LOCKED) && acquiring)
        lock_time <= lock_span; // R11
      if (!genlock_en)
        was_locked <= 1'b0;
      else if ((state == ST_LOCKED) && !seen_ref)
        was_locked <= 1'b1; // R10
      // A tolerated jump keeps lock and lets the outputs walk to the new phase.
      if (next_state != ST_LOCKED)
      begin
        drift_active <= 1'b0;
        drift_lines <= 16'h0000;
      end
      else if ((state == ST_LOCKED) && disturbance)
      begin
        drift_active <= 1'b1; // R18
        drift_lines <= 16'h0000;
      end
      else if (drift_active && hs_rise)
      begin
        if (drift_lines >= `GLS_DRIFT_LOCK_LINES)
          drift_active <= 1'b0;
        else
          drift_lines <= drift_lines + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Host registers
  // --------------------------------------------------------------------------
  // Writes land in one cycle; the audio dividers remember that the host
  // took them over, since the defaults only fit the built-in clocks.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lock_mode <= `GLS_RST_LOCK_MODE;
      crash_win <= `GLS_RST_CRASH_WIN;
      video_cap <= `GLS_RST_VCAP;
      video_res <= `GLS_RST_VRES;
      video_ref_div <= `GLS_RST_VDIV;
      aud_ctrl <= `GLS_RST_AUD_CTRL; // R06
      audio_cap <= `GLS_RST_ACAP;
      audio_res <= `GLS_RST_ARES;
      audio_fb_div <= AUD_DEFAULT_NUM; // R01
      audio_ref_div <= AUD_DEFAULT_DEN; // R01
      audio_custom_div <= 1'b0;
      line_rst <= `GLS_RST_LINE_RST;
    end
    else if (host_wr)
    begin
      case (host_addr)
        `GLS_ADDR_LOCK_MODE: lock_mode <= host_wdata;
        `GLS_ADDR_CRASH_WIN: crash_win <= host_wdata;
        `GLS_ADDR_VCAP: video_cap <= host_wdata; // R12
        `GLS_ADDR_VRES: video_res <= host_wdata; // R12
        `GLS_ADDR_VDIV_LO: video_ref_div[15:0] <= host_wdata;
        `GLS_ADDR_VDIV_HI: video_ref_div[31:16] <= host_wdata;
        `GLS_ADDR_AUD_CTRL: aud_ctrl <= host_wdata; // R06
        `GLS_ADDR_ACAP: audio_cap <= host_wdata; // R15
        `GLS_ADDR_ARES: audio_res <= host_wdata; // R15
        `GLS_ADDR_ANUM_LO:
        begin
          audio_fb_div[15:0] <= host_wdata;
          audio_custom_div <= 1'b1;
        end
        `GLS_ADDR_ANUM_HI:
        begin
          audio_fb_div[31:16] <= host_wdata;
          audio_custom_div <= 1'b1;
        end
        `GLS_ADDR_ADEN_LO:
        begin
          audio_ref_div[15:0] <= host_wdata;
          audio_custom_div <= 1'b1;
        end
        `GLS_ADDR_ADEN_HI:
        begin
          audio_ref_div[31:16] <= host_wdata;
          audio_custom_div <= 1'b1;
        end
        `GLS_ADDR_LINE_RST: line_rst <= host_wdata;
        default: line_rst <= line_rst;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      host_rdata <= 16'h0000;
    else if (host_rd)
    begin
      case (host_addr)
        `GLS_ADDR_LOCK_TIME: host_rdata <= lock_time;
        `GLS_ADDR_STATUS: host_rdata <= {1'b0, eff_rate, 2'b00, state, 2'b00, audio_custom_div,
          vphase_aligned, lock_crash_mode, drift_active, ref_lost, lock_lost};
        `GLS_ADDR_LOCK_MODE: host_rdata <= lock_mode;
        `GLS_ADDR_CRASH_WIN: host_rdata <= crash_win;
        `GLS_ADDR_VCAP: host_rdata <= video_cap;
        `GLS_ADDR_VRES: host_rdata <= video_res;
        `GLS_ADDR_VDIV_LO: host_rdata <= video_ref_div[15:0];
        `GLS_ADDR_VDIV_HI: host_rdata <= video_ref_div[31:16];
        `GLS_ADDR_AUD_CTRL: host_rdata <= aud_ctrl;
        `GLS_ADDR_ACAP: host_rdata <= audio_cap;
        `GLS_ADDR_ARES: host_rdata <= audio_res;
        `GLS_ADDR_ANUM_LO: host_rdata <= audio_fb_div[15:0];
        `GLS_ADDR_ANUM_HI: host_rdata <= audio_fb_div[31:16];
        `GLS_ADDR_ADEN_LO: host_rdata <= audio_ref_div[15:0];
        `GLS_ADDR_ADEN_HI: host_rdata <= audio_ref_div[31:16];
        `GLS_ADDR_LINE_RST: host_rdata <= line_rst;
        default: host_rdata <= 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Audio ratio constant
  // --------------------------------------------------------------------------
  assign eff_rate = aud_ctrl[`GLS_AC_RATE_OVR_BIT] ? aud_ctrl[`GLS_AC_RATE_MSB:`GLS_AC_RATE_LSB] : rate_pin;

  // The constant follows the effective rate select and the high-multiple flag.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      audio_ratio_const <= `GLS_RATIO_DEFAULT;
    else if (eff_rate != `GLS_RATE_96K)
      audio_ratio_const <= `GLS_RATIO_DEFAULT; // R03
    else if (aud_ctrl[`GLS_AC_HIGH_MULT_BIT])
      audio_ratio_const <= `GLS_RATIO_96K_HIGH; // R03
    else
      audio_ratio_const <= `GLS_RATIO_96K_LOW; // R03
  end

  // --------------------------------------------------------------------------
  // Line-based counters
  // --------------------------------------------------------------------------
  // Only the falling edge of the reset bit acts, so a one-then-zero pair
  // gives a single reset rather than two.
  assign lr_fall = lr_prev & ~line_rst[`GLS_LR_TOGGLE_BIT]; // R22

  // Counters realign at the first vertical sync after a reset; a jump with
  // a divider above one leaves them free-running at the old frame length.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lr_prev <= 1'b0;
      align_pending <= 1'b0;
      vphase_aligned <= 1'b1;
      line_count <= 16'h0000;
      line_total <= 16'hFFFF;
      line_counter_reset <= 1'b0;
      line_frame_start <= 1'b0;
    end
    else
    begin
      lr_prev <= line_rst[`GLS_LR_TOGGLE_BIT];
      line_counter_reset <= lr_fall; // R21
      line_frame_start <= hs_rise && vphase_aligned
        && (line_count == {5'h00, line_rst[`GLS_LR_VOFS_MSB:`GLS_LR_VOFS_LSB]}); // R21
      if (lr_fall)
      begin
        align_pending <= 1'b1; // R21
        line_count <= 16'h0000;
      end
      else if (vs_rise && (vphase_aligned || align_pending))
      begin
        align_pending <= 1'b0;
        vphase_aligned <= 1'b1;
        line_total <= line_count;
        line_count <= 16'h0000;
      end
      else if (hs_rise)
      begin
        if (!vphase_aligned && (line_count >= line_total))
          line_count <= 16'h0000;
        else
          line_count <= line_count + 16'h0001;
      end
      if (disturbance && !lr_fall && (video_ref_div > 32'h00000001))
        vphase_aligned <= 1'b0; // R20
    end
  end

endmodule // gls_lock_ctrl

// *** gls_ref_src.sv ***
`timescale 1ns/1ps
// Reference H source: 40-cycle lines, one 60-cycle line after jump.
module gls_ref_src (
  input wire clk, // System clock.
  input wire rst_b, // Reset, active low.
  input wire en, // Reference applied.
  input wire jump, // Stretch one line to move the H phase.
  output reg hsync // Reference H pulse, low while not applied.
);
  reg [6:0] cnt;
  reg long;
  wire wrap = (cnt == (long ? 7'h3B : 7'h27));
  // The phase moves without any gap, so the reference is never lost.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 7'h00;
      long <= 1'b0;
      hsync <= 1'b0;
    end
    else
    begin
      cnt <= (!en || wrap) ? 7'h00 : cnt + 7'h01;
      long <= jump ? 1'b1 : (wrap ? 1'b0 : long);
      hsync <= en && (cnt < 7'h02);
    end
  end
endmodule // gls_ref_src

// *** gls_lock_ctrl_props.sv ***
`timescale 1ns/1ps
module gls_lock_ctrl_props (
  input wire clk, // Clock.
  input wire rst_b, // Reset, active low.
  input wire host_wr, // Write strobe.
  input wire [7:0] host_addr, // Address.
  input wire [15:0] host_wdata, // Write data.
  input wire lock_lost, // Not locked.
  input wire ref_lost, // No reference.
  input wire lock_crash_mode, // Crash running.
  input wire phase_jump, // Crash start pulse.
  input wire drift_active, // Drifting.
  input wire [15:0] video_cap, // Video capacitive.
  input wire [15:0] audio_cap, // Audio capacitive.
  input wire line_counter_reset, // Line reset pulse.
  input wire [15:0] line_count // Line count.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg [3:0] clr_hist;
  // Recent writes of 83h; a reset pulse must follow one of them.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      clr_hist <= 4'h0;
    else
      clr_hist <= {clr_hist[2:0], host_wr && host_addr == 8'h83};
  end
  sequence s_cap_wr;
    host_wr && host_addr == 8'h26;
  endsequence
  sequence s_acap_wr;
    host_wr && host_addr == 8'h39;
  endsequence
  a_jump_once: assert property (phase_jump |=> !phase_jump) else $error("jump pulse long");
  a_jump_crash: assert property (phase_jump |-> ##[0:1] lock_crash_mode) else $error("no crash");
  a_crash_unlocked: assert property (lock_crash_mode |-> lock_lost) else $error("crash locked");
  a_drift_flags: assert property (drift_active |-> !lock_lost && !ref_lost) else $error("drift flag");
  a_drift_nojump: assert property (drift_active |-> !phase_jump) else $error("drift jumped");
  a_line_once: assert property (line_counter_reset |=> !line_counter_reset) else $error("line pulse");
  a_line_zero: assert property (line_counter_reset |-> ##[0:1] line_count == 16'h0000) else $error("count");
  a_line_cause: assert property (line_counter_reset |-> |clr_hist) else $error("line cause");
  a_vcap_write: assert property (s_cap_wr |=> video_cap == $past(host_wdata)) else $error("vcap");
  a_acap_write: assert property (s_acap_wr |=> audio_cap == $past(host_wdata)) else $error("acap");
endmodule // gls_lock_ctrl_props

// *** gls_lock_ctrl_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module gls_lock_ctrl_bench;
  reg clk = 1'b0, rst_b = 1'b0, host_wr = 1'b0, host_rd = 1'b0, en = 1'b0, jump = 1'b0;
  reg [7:0] host_addr = 8'h00;
  reg [15:0] host_wdata = 16'h0000, d;
  reg [2:0] audio_rate_select = 3'h3;
  wire hs, lock_lost, ref_lost, lock_crash_mode, phase_jump, drift_active, audio_custom_div;
  wire line_counter_reset, lfs;
  wire [15:0] host_rdata, video_cap, video_res, audio_cap, audio_res, line_count;
  wire [11:0] audio_ratio_const;
  wire [31:0] audio_fb_div, audio_ref_div;
  reg [23:0] tbl [0:6];
  int num_errors = 0, compares = 0, i;
  // A 200 MHz clock.
  always #2.5 clk = ~clk;
  gls_ref_src SRC (.clk(clk), .rst_b(rst_b), .en(en), .jump(jump), .hsync(hs));
  gls_lock_ctrl #(.REF_TIMEOUT_CYCLES(64)) DUT (.clk(clk), .rst_b(rst_b), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .ref_hsync(hs), .ref_vsync(1'b0), .audio_rate_select(audio_rate_select), .lock_lost(lock_lost),
    .ref_lost(ref_lost), .lock_crash_mode(lock_crash_mode), .phase_jump(phase_jump),
    .drift_active(drift_active), .audio_ratio_const(audio_ratio_const), .audio_fb_div(audio_fb_div),
    .audio_ref_div(audio_ref_div), .audio_custom_div(audio_custom_div), .video_ref_div(),
    .video_cap(video_cap), .video_res(video_res), .audio_cap(audio_cap), .audio_res(audio_res),
    .line_counter_reset(line_counter_reset), .line_frame_start(lfs), .line_count(line_count),
    .vphase_aligned());
  // Tasks start and end on a falling edge, so strobes never change twice in one step.
  task wr(input [7:0] a, input [15:0] v);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = v;
    @(negedge clk);
    host_wr = 1'b0;
    @(negedge clk);
  endtask
  task rd(input [7:0] a);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk);
    host_rd = 1'b0;
    @(negedge clk);
    d = host_rdata;
  endtask
  task close_out;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bounded wait: 0 locked, 1 drifting, 2 crash start, 3 line reset, 4 frame start.
  task waitsig(input int s);
    for (i = 0; i < 4000; i++)
    begin
      if ((s == 0 && lock_lost === 1'b0) || (s == 1 && drift_active === 1'b1) ||
          (s == 2 && phase_jump === 1'b1) || (s == 3 && line_counter_reset === 1'b1) ||
          (s == 4 && lfs === 1'b1))
        break;
      @(negedge clk);
    end
    if (i == 4000)
    begin
      num_errors++;
      close_out;
    end
  endtask
  task t_reset;
    tbl[0] = 24'h160001; tbl[1] = 24'h240047; tbl[2] = 24'h260010; tbl[3] = 24'h270025;
    tbl[4] = 24'h310000; tbl[5] = 24'h390010; tbl[6] = 24'h3A0025;
    for (int k = 0; k < 7; k++)
    begin
      rd(tbl[k][23:16]);
      `CHK(d, tbl[k][15:0])
    end
    `CHK(audio_ratio_const, 12'hC00)
    `CHK(audio_fb_div, 32'h00000001)
  endtask
  task t_ratio;
    audio_rate_select = 3'h4;
    repeat (8) @(negedge clk);
    `CHK(audio_ratio_const, 12'h400)
    wr(8'h31, 16'h0020);
    repeat (4) @(negedge clk);
    `CHK(audio_ratio_const, 12'h600)
    wr(8'h31, 16'h0324);
    repeat (4) @(negedge clk);
    `CHK(audio_ratio_const, 12'hC00)
    wr(8'h31, 16'h0000);
  endtask
  task t_filter;
    wr(8'h26, 16'h000B);
    wr(8'h27, 16'h0020);
    wr(8'h39, 16'h0015);
    wr(8'h3A, 16'h002A);
    wr(8'h3B, 16'h0700);
    wr(8'h3D, 16'h0465);
    `CHK({video_cap, video_res, audio_cap, audio_res}, 64'h000B00200015002A)
    `CHK({audio_fb_div, audio_ref_div}, 64'h0000070000000465)
    `CHK(audio_custom_div, 1'b1)
  endtask
  task t_lock;
    en = 1'b1;
    waitsig(2);
    waitsig(0);
    `CHK({ref_lost, lock_crash_mode}, 2'h0)
  endtask
  task t_jump(input [15:0] win, input int s);
    wr(8'h24, win);
    jump = 1'b1;
    @(negedge clk);
    jump = 0;
    waitsig(s);
    `CHK({ref_lost, lock_lost}, {1'b0, s == 2})
  endtask
  task t_line;
    wr(8'h83, 16'h8000);
    wr(8'h83, 16'h0000);
    waitsig(3);
    `CHK({line_counter_reset, line_count}, 17'h10000)
    @(negedge clk);
    `CHK(line_counter_reset, 1'b0)
    waitsig(4);
    `CHK(line_count, 16'h0001)
  endtask
  // Lock, pull the reference long enough to lose it, then bring it back.
  task t_relock;
    waitsig(0);
    en = 1'b0;
    repeat (120) @(negedge clk);
    en = 1'b1;
    repeat (90) @(negedge clk);
    rd(8'h15);
    `CHK({d[9:8], d[3], d[1]}, 4'h8)
  endtask
  // Main sequence: reset for 4 cycles, then one task per behaviour.
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset;
    t_ratio;
    t_filter;
    t_lock;
    t_jump(16'h0047, 1);
    t_jump(16'h0040, 2);
    t_line;
    t_relock;
    close_out;
  end
endmodule // gls_lock_ctrl_bench
bind gls_lock_ctrl gls_lock_ctrl_props u_props (.clk(clk), .rst_b(rst_b), .host_wr(host_wr),
  .host_addr(host_addr), .host_wdata(host_wdata), .lock_lost(lock_lost), .ref_lost(ref_lost),
  .lock_crash_mode(lock_crash_mode), .phase_jump(phase_jump), .drift_active(drift_active),
  .video_cap(video_cap), .audio_cap(audio_cap), .line_counter_reset(line_counter_reset),
  .line_count(line_count));
